// ---- inc/csw_pkg.sv ----
// Package for the stack-transfer / wait decoder block.
// Assumes a single 100 MHz clock domain and a byte-wide system bus.
package csw_pkg;
  localparam logic [7:0]  OP_INDEX_TO_STACK_PTR = 8'h94;
  localparam logic [7:0]  OP_WAIT               = 8'h8F;
  localparam logic [15:0] VECTOR_PAGE           = 16'hFF00;
  localparam logic [15:0] STACK_PTR_RESET       = 16'h00FF;
  localparam logic [15:0] PC_RESET              = 16'h0000;
  localparam logic [7:0]  VEC_LOW_IRQ           = 8'hF8;
  localparam int          CLK_PERIOD_NS         = 10;
  // Bus-cycle codes
  typedef enum logic [2:0] {
    CSW_CYC_FREE  = 3'h0,
    CSW_CYC_PROG  = 3'h1,
    CSW_CYC_READ  = 3'h2,
    CSW_CYC_PUSH  = 3'h3,
    CSW_CYC_POP   = 3'h4,
    CSW_CYC_VEC   = 3'h5,
    CSW_CYC_WRITE = 3'h6
  } csw_cyc_e;
  // Addressing modes used by the address generator
  typedef enum logic [2:0] {
    CSW_AM_REL        = 3'h0,
    CSW_AM_DIR        = 3'h1,
    CSW_AM_IX_PI      = 3'h2,
    CSW_AM_IX1_PI     = 3'h3,
    CSW_AM_SP1        = 3'h4,
    CSW_AM_SP2        = 3'h5
  } csw_am_e;
endpackage : csw_pkg

// ---- verilog/csw_decode.sv ----
// Decoder for stack-pointer transfer and wait, with bus-cycle sequencing
// and an effective-address generator for the listed operand modes.
// Assumes memory answers reads in the same cycle on i_rdata.
//
// Notes on behaviour
// - Opcode 94 loads stack_ptr with index pair minus one; 2 cycles.
// - Opcode 8F clears interrupt mask, then halts; at least 2 cycles.
// - A free cycle lasts one clock, needs no transfer, reads.
// - Vector cycles read page FFxx, high byte before low byte.
// - Branch target is next instruction plus signed 8-bit offset.
// - Direct mode: operand byte is low address, high byte zero.
// - Push writes exactly one byte; pop reads exactly one byte; this block issues neither.
// - Each program fetch reads the next location; PC advances by one.
// - Post-increment modes use index pair plus 0 or 8-bit offset.
// - Stack modes add unsigned 8-bit or 16-bit offset to stack_ptr.
`timescale 1ns/10ps
module csw_decode (
  // Clock and reset
  input  wire logic                 i_clk,
  input  wire logic                 i_rst_b,
  input  wire logic                 i_ce,
  // Instruction issue
  input  wire logic                 i_op_valid,
  input  wire logic [7:0]           i_opcode,
  input  wire logic [15:0]          i_index_pair,
  // Interrupt request pin
  input  wire logic                 i_irq,
  // Address generator request
  input  wire logic                 i_ea_req,
  input  wire csw_pkg::csw_am_e     i_ea_mode,
  input  wire logic [15:0]          i_ea_oper,
  input  wire logic [15:0]          i_next_pc,
  // Memory read data
  input  wire logic [7:0]           i_rdata,
  // System bus
  output logic [15:0]               o_addr,
  output logic                      o_rd,
  output logic                      o_wr,
  output logic [7:0]                o_wdata,
  output csw_pkg::csw_cyc_e         o_cyc,
  // CPU state
  output logic [15:0]               o_stack_ptr,
  output logic [15:0]               o_pc,
  output logic [15:0]               o_index_pair,
  output logic                      o_int_mask,
  output logic                      o_halted,
  output logic                      o_busy,
  output logic [15:0]               o_ea,
  output logic                      o_ea_valid
);
  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_FREE  = 6'b000010,
    ST_FETCH = 6'b000100,
    ST_HALT  = 6'b001000,
    ST_VECH  = 6'b010000,
    ST_VECL  = 6'b100000
  } csw_st_e;

  csw_st_e      st_ff, nxt_st;
  logic         is_txs_ff, nxt_is_txs;
  logic [15:0]  sp_ff, pc_ff, hx_ff, addr_ff, ea_ff;
  logic         imask_ff, rd_ff, ea_v_ff;
  logic         busy_ff, halted_ff;
  logic [7:0]   vech_ff;
  csw_pkg::csw_cyc_e cyc_ff;
  logic         irq_s1_ff, irq_s2_ff;

  wire logic dec_txs  = i_op_valid &&
                        (i_opcode == csw_pkg::OP_INDEX_TO_STACK_PTR);
  wire logic dec_wait = i_op_valid && (i_opcode == csw_pkg::OP_WAIT);
  wire logic wake     = irq_s2_ff && !imask_ff;
  wire logic [15:0] hx_m1 = i_index_pair - 16'h0001;
  wire logic [15:0] rel_sx = {{8{i_ea_oper[7]}}, i_ea_oper[7:0]};

  // Effective address per mode
  logic [15:0] ea_calc;
  always_comb begin
    ea_calc = 16'h0000;
    unique case (i_ea_mode)
      csw_pkg::CSW_AM_REL:    ea_calc = i_next_pc + rel_sx;
      csw_pkg::CSW_AM_DIR:    ea_calc = {8'h00, i_ea_oper[7:0]};
      csw_pkg::CSW_AM_IX_PI:  ea_calc = hx_ff;
      csw_pkg::CSW_AM_IX1_PI:
        ea_calc = hx_ff + {8'h00, i_ea_oper[7:0]};
      csw_pkg::CSW_AM_SP1:
        ea_calc = sp_ff + {8'h00, i_ea_oper[7:0]};
      csw_pkg::CSW_AM_SP2:    ea_calc = sp_ff + i_ea_oper;
      default:                ea_calc = 16'h0000;
    endcase
  end
  wire logic ea_postinc = i_ea_req &&
    (i_ea_mode == csw_pkg::CSW_AM_IX_PI || i_ea_mode == csw_pkg::CSW_AM_IX1_PI);

  always_comb begin
    nxt_st = st_ff;
    nxt_is_txs = is_txs_ff;
    unique case (st_ff)
      ST_IDLE: begin
        if (dec_txs || dec_wait) begin
          nxt_st = ST_FREE;
          nxt_is_txs = dec_txs;
        end
      end
      ST_FREE:  nxt_st = ST_FETCH;
      ST_FETCH: nxt_st = is_txs_ff ? ST_IDLE : ST_HALT;
      ST_HALT:  nxt_st = wake ? ST_VECH : ST_HALT;
      ST_VECH:  nxt_st = ST_VECL;
      ST_VECL:  nxt_st = ST_IDLE;
      default:  nxt_st = ST_IDLE;
    endcase
  end

  // Synchroniser for the interrupt pin
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      irq_s1_ff <= 1'b0;
      irq_s2_ff <= 1'b0;
    end else if (i_ce) begin
      irq_s1_ff <= i_irq;
      irq_s2_ff <= irq_s1_ff;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_ff     <= ST_IDLE;
      is_txs_ff <= 1'b0;
      busy_ff   <= 1'b0;
      halted_ff <= 1'b0;
    end else if (i_ce) begin
      st_ff     <= nxt_st;
      is_txs_ff <= nxt_is_txs;
      // Registered so the status pins settle with the state, not after it
      busy_ff   <= (nxt_st != ST_IDLE);
      halted_ff <= (nxt_st == ST_HALT);
    end
  end

  // Architectural registers; condition codes other than the mask untouched
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sp_ff    <= csw_pkg::STACK_PTR_RESET;
      pc_ff    <= csw_pkg::PC_RESET;
      hx_ff    <= 16'h0000;
      imask_ff <= 1'b1;
      vech_ff  <= 8'h00;
    end else if (i_ce) begin
      if (st_ff == ST_IDLE && dec_txs)
        sp_ff <= hx_m1;
      if (st_ff == ST_IDLE && dec_wait)
        imask_ff <= 1'b0;
      else if (st_ff == ST_VECH)
        imask_ff <= 1'b1;
      if (st_ff == ST_IDLE && i_op_valid)
        hx_ff <= i_index_pair;
      else if (ea_postinc)
        hx_ff <= hx_ff + 16'h0001;
      if (st_ff == ST_FETCH)
        pc_ff <= pc_ff + 16'h0001;
      else if (st_ff == ST_VECH)
        vech_ff <= i_rdata;
      else if (st_ff == ST_VECL)
        pc_ff <= {vech_ff, i_rdata};
    end
  end

  // Bus outputs registered for the next state's cycle
  csw_pkg::csw_cyc_e nxt_cyc;
  logic [15:0] nxt_addr;
  always_comb begin
    nxt_cyc  = csw_pkg::CSW_CYC_FREE;
    nxt_addr = addr_ff;
    unique case (nxt_st)
      ST_FREE:  nxt_cyc = csw_pkg::CSW_CYC_FREE;
      ST_FETCH: begin
        nxt_cyc  = csw_pkg::CSW_CYC_PROG;
        nxt_addr = pc_ff;
      end
      ST_VECH: begin
        nxt_cyc  = csw_pkg::CSW_CYC_VEC;
        nxt_addr = csw_pkg::VECTOR_PAGE | {8'h00, csw_pkg::VEC_LOW_IRQ};
      end
      ST_VECL: begin
        nxt_cyc  = csw_pkg::CSW_CYC_VEC;
        nxt_addr = csw_pkg::VECTOR_PAGE |
                   {8'h00, csw_pkg::VEC_LOW_IRQ + 8'h01};
      end
      default:  nxt_cyc = csw_pkg::CSW_CYC_FREE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cyc_ff  <= csw_pkg::CSW_CYC_FREE;
      addr_ff <= 16'h0000;
      rd_ff   <= 1'b1;
      ea_ff   <= 16'h0000;
      ea_v_ff <= 1'b0;
    end else if (i_ce) begin
      cyc_ff  <= nxt_cyc;
      addr_ff <= nxt_addr;
      rd_ff   <= 1'b1;  // Every cycle here is a read; no push or pop yet
      ea_v_ff <= i_ea_req;
      if (i_ea_req)
        ea_ff <= ea_calc;
    end
  end

  assign o_addr       = addr_ff;
  assign o_rd         = rd_ff;
  assign o_wr         = 1'b0; // this block issues no push beats
  assign o_wdata      = 8'h00;
  assign o_cyc        = cyc_ff;
  assign o_stack_ptr  = sp_ff;
  assign o_pc         = pc_ff;
  assign o_index_pair = hx_ff;
  assign o_int_mask   = imask_ff;
  assign o_halted     = halted_ff;
  assign o_busy       = busy_ff;
  assign o_ea         = ea_ff;
  assign o_ea_valid   = ea_v_ff;

  // Checks on internal state; the bench only sees the registered pins
  a_txs_load: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (i_ce && st_ff == ST_IDLE && dec_txs) |=> sp_ff == $past(hx_m1))
    else $error("stack_ptr not loaded from index pair minus one");
  a_txs_two_cyc: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (i_ce && st_ff == ST_IDLE && dec_txs) ##1 i_ce [*2]
      |=> st_ff == ST_IDLE)
    else $error("transfer did not finish in two cycles");
  a_txs_mask: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (i_ce && st_ff == ST_IDLE && dec_txs) |=> imask_ff == $past(imask_ff))
    else $error("transfer changed the interrupt mask");
  a_ignore_op: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (i_ce && st_ff == ST_IDLE && i_op_valid && !dec_txs && !dec_wait)
      |=> st_ff == ST_IDLE && sp_ff == $past(sp_ff))
    else $error("unsupported opcode was acted on");
  a_busy_out: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    o_busy == (st_ff != ST_IDLE))
    else $error("busy pin out of step with sequencer");
  a_wait_mask: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (i_ce && st_ff == ST_IDLE && dec_wait) |=> !imask_ff)
    else $error("wait did not clear interrupt mask");
  a_wait_halt: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (i_ce && st_ff == ST_IDLE && dec_wait) ##1 i_ce [*2]
      |=> st_ff == ST_HALT)
    else $error("wait did not halt after free and fetch");
  a_halt_out: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    o_halted == (st_ff == ST_HALT))
    else $error("halted pin out of step with sequencer");
  a_free_read: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (st_ff == ST_FREE)
      |-> (o_cyc == csw_pkg::CSW_CYC_FREE && o_rd && !o_wr))
    else $error("free cycle not shown as read");
  a_vec_order: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (st_ff == ST_VECH) |-> o_addr[15:8] == 8'hFF && o_addr[0] == 1'b0)
    else $error("vector high byte not read first from top page");
  a_vec_low: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (st_ff == ST_VECL) |-> o_cyc == csw_pkg::CSW_CYC_VEC &&
      o_addr[15:8] == 8'hFF && o_addr[0] == 1'b1)
    else $error("vector low byte not read second from top page");
  a_vec_pc: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (i_ce && st_ff == ST_VECH) ##1 (i_ce && st_ff == ST_VECL)
      |=> pc_ff == {$past(i_rdata, 2), $past(i_rdata)})
    else $error("vector bytes not joined high then low");
  a_rel_target: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (i_ce && i_ea_req && i_ea_mode == csw_pkg::CSW_AM_REL)
      |=> o_ea == $past(i_next_pc) +
          {{8{$past(i_ea_oper[7])}}, $past(i_ea_oper[7:0])})
    else $error("branch target not next address plus signed offset");
  a_dir_page: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (i_ce && i_ea_req && i_ea_mode == csw_pkg::CSW_AM_DIR)
      |=> o_ea[15:8] == 8'h00 && o_ea_valid)
    else $error("direct address high byte not zero");
  a_pc_step: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (i_ce && st_ff == ST_FETCH) |=> pc_ff == $past(pc_ff) + 16'h0001)
    else $error("program counter did not advance by one");
  a_fetch_addr: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (st_ff == ST_FETCH)
      |-> o_cyc == csw_pkg::CSW_CYC_PROG && o_addr == pc_ff)
    else $error("program fetch not at current program counter");
  a_postinc: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (i_ce && ea_postinc && !(st_ff == ST_IDLE && i_op_valid))
      |=> hx_ff == $past(hx_ff) + 16'h0001)
    else $error("index pair not incremented after access");
  a_ix1_sum: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (i_ce && i_ea_req && i_ea_mode == csw_pkg::CSW_AM_IX1_PI)
      |=> o_ea == $past(hx_ff) + {8'h00, $past(i_ea_oper[7:0])})
    else $error("indexed offset address not index pair plus offset");
  a_sp1_sum: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (i_ce && i_ea_req && i_ea_mode == csw_pkg::CSW_AM_SP1)
      |=> o_ea == $past(sp_ff) + {8'h00, $past(i_ea_oper[7:0])})
    else $error("stack 8-bit offset address wrong");
  a_sp2_sum: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (i_ce && i_ea_req && i_ea_mode == csw_pkg::CSW_AM_SP2)
      |=> o_ea == $past(sp_ff) + $past(i_ea_oper))
    else $error("stack 16-bit offset address wrong");
  a_halt_hold: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (st_ff == ST_HALT && !(irq_s2_ff && !imask_ff)) |=> st_ff == ST_HALT)
    else $error("left halt without unmasked interrupt");
endmodule : csw_decode

// ---- dv/csw_mem_model.sv ----
// Behavioural program/data memory on the system bus.
// Assumes reads are answered in the same cycle, as the decoder expects.
`timescale 1ns/10ps
module csw_mem_model (
  // Bus from the decoder
  input  wire logic [15:0] i_addr,
  input  wire logic        i_rd,
  // Read data back
  output logic      [7:0]  o_rdata
);
  // Vector bytes differ so a swapped high/low fetch shows up in pc
  wire logic [7:0] mem_byte = (i_addr == 16'hFFF8) ? 8'hC3 :
                              (i_addr == 16'hFFF9) ? 8'h5A :
                              (i_addr[7:0] ^ i_addr[15:8]);
  // Not reading: drive a non-idle pattern rather than stale data
  assign o_rdata = i_rd ? mem_byte : ~mem_byte;
endmodule : csw_mem_model

// ---- dv/tb_top.sv ----
// Self-checking bench for the stack-transfer / wait decoder.
// Assumes the memory model on the bus and one 100 MHz clock.
`timescale 1ns/10ps
module tb_top;
  logic i_clk, i_rst_b, i_ce, i_op_valid, i_irq, i_ea_req;
  logic [7:0] i_opcode, i_rdata, o_wdata;
  logic [15:0] i_index_pair, i_ea_oper, i_next_pc, o_addr, o_stack_ptr;
  logic [15:0] o_pc, o_index_pair, o_ea;
  logic o_rd, o_wr, o_int_mask, o_halted, o_busy, o_ea_valid;
  csw_pkg::csw_am_e i_ea_mode;
  csw_pkg::csw_cyc_e o_cyc;
  int fail_count = 0;
  int comparisons = 0;
  csw_decode csw_decode_i (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(i_ce),
    .i_op_valid(i_op_valid), .i_opcode(i_opcode),
    .i_index_pair(i_index_pair), .i_irq(i_irq), .i_ea_req(i_ea_req),
    .i_ea_mode(i_ea_mode), .i_ea_oper(i_ea_oper), .i_next_pc(i_next_pc),
    .i_rdata(i_rdata), .o_addr(o_addr), .o_rd(o_rd), .o_wr(o_wr),
    .o_wdata(o_wdata), .o_cyc(o_cyc), .o_stack_ptr(o_stack_ptr),
    .o_pc(o_pc), .o_index_pair(o_index_pair), .o_int_mask(o_int_mask),
    .o_halted(o_halted), .o_busy(o_busy), .o_ea(o_ea),
    .o_ea_valid(o_ea_valid));
  csw_mem_model csw_mem_model_i (.i_addr(o_addr), .i_rd(o_rd),
    .o_rdata(i_rdata));
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  task automatic tally_and_finish();
    if (fail_count == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // Issue one opcode; returns just after the edge that takes it
  task automatic issue(input logic [7:0] op, input logic [15:0] hx);
    @(posedge i_clk);
    i_op_valid <= 1'b1;
    i_opcode <= op;
    i_index_pair <= hx;
    @(posedge i_clk);
    i_op_valid <= 1'b0;
    #1;
  endtask : issue
  task automatic run_txs(input logic [15:0] hx);
    logic [15:0] pc0;
    pc0 = o_pc;
    issue(csw_pkg::OP_INDEX_TO_STACK_PTR, hx);
    chk(o_stack_ptr, hx - 16'h0001);
    chk({o_busy, o_rd, o_wr, 10'h0, o_cyc}, {3'b110, 10'h0, 3'h0});
    chk({8'h00, o_wdata}, 16'h0000);
    @(posedge i_clk);
    #1;
    chk({13'h0, o_cyc}, 16'h0001);
    chk(o_addr, pc0);
    @(posedge i_clk);
    #1;
    chk(o_pc, pc0 + 16'h0001);
    chk({15'h0, o_busy}, 16'h0000);
    chk({15'h0, o_int_mask}, 16'h0001);
  endtask : run_txs
  task automatic run_ignored();
    @(posedge i_clk);
    i_op_valid <= 1'b1;
    i_opcode <= 8'h95;
    i_index_pair <= 16'h4321;
    repeat (3) @(posedge i_clk);
    i_op_valid <= 1'b0;
    #1;
    chk({15'h0, o_busy}, 16'h0000);
    chk(o_stack_ptr, 16'hFFFF);
  endtask : run_ignored
  // Clock enable low: an opcode offered then must leave no trace
  task automatic run_freeze();
    @(posedge i_clk);
    i_ce <= 1'b0;
    i_op_valid <= 1'b1;
    i_opcode <= csw_pkg::OP_INDEX_TO_STACK_PTR;
    i_index_pair <= 16'h5555;
    repeat (2) @(posedge i_clk);
    i_op_valid <= 1'b0;
    i_ce <= 1'b1;
    #1;
    chk(o_stack_ptr, 16'hFFFF);
    chk(o_index_pair, 16'h4321);
    chk({15'h0, o_busy}, 16'h0000);
  endtask : run_freeze
  task automatic run_ea(input csw_pkg::csw_am_e m, input logic [15:0] opr,
                        input logic [15:0] exp, input logic [15:0] hx_after);
    @(posedge i_clk);
    i_ea_req <= 1'b1;
    i_ea_mode <= m;
    i_ea_oper <= opr;
    @(posedge i_clk);
    i_ea_req <= 1'b0;
    #1;
    chk(o_ea, exp);
    chk({15'h0, o_ea_valid}, 16'h0001);
    @(posedge i_clk);
    #1;
    chk({15'h0, o_ea_valid}, 16'h0000);
    chk(o_index_pair, hx_after);
  endtask : run_ea
  task automatic run_wait();
    int n;
    issue(csw_pkg::OP_WAIT, 16'h0000);
    chk({15'h0, o_int_mask}, 16'h0000);
    chk({13'h0, o_cyc}, 16'h0000);
    repeat (2) @(posedge i_clk);
    #1;
    chk({15'h0, o_halted}, 16'h0001);
    repeat (6) @(posedge i_clk);
    i_irq <= 1'b1;
    #1;
    chk({15'h0, o_halted}, 16'h0001);
    n = 0;
    while (o_cyc !== csw_pkg::CSW_CYC_VEC && n < 10) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    if (n >= 10) begin
      fail_count++;
      tally_and_finish();
    end
    chk(o_addr, 16'hFFF8);
    @(posedge i_clk);
    i_irq <= 1'b0;
    #1;
    chk({13'h0, o_cyc}, 16'h0005);
    chk(o_addr, 16'hFFF9);
    @(posedge i_clk);
    #1;
    chk(o_pc, 16'hC35A);
    chk({14'h0, o_int_mask, o_halted}, 16'h0002);
  endtask : run_wait
  // Reset is the other way out of a wait
  task automatic run_wait_reset();
    issue(csw_pkg::OP_WAIT, 16'h0000);
    repeat (2) @(posedge i_clk);
    #1;
    chk({15'h0, o_halted}, 16'h0001);
    @(posedge i_clk);
    i_rst_b <= 1'b0;
    @(posedge i_clk);
    i_rst_b <= 1'b1;
    #1;
    chk({14'h0, o_halted, o_busy}, 16'h0000);
    chk({15'h0, o_int_mask}, 16'h0001);
    chk(o_pc, csw_pkg::PC_RESET);
  endtask : run_wait_reset
  initial begin
    i_rst_b = 1'b0;
    {i_op_valid, i_irq, i_ea_req} = 3'b000;
    i_ce = 1'b1;
    i_opcode = 8'h00;
    i_index_pair = 16'h0000;
    i_ea_mode = csw_pkg::CSW_AM_REL;
    i_ea_oper = 16'h0000;
    i_next_pc = 16'h1000;
    repeat (5) @(posedge i_clk);
    i_rst_b <= 1'b1;
    #1;
    chk(o_stack_ptr, 16'h00FF);
    chk({o_pc[14:0], o_int_mask}, 16'h0001);
    run_txs(16'h1234);
    run_txs(16'h0000);
    // An offered opcode reloads the index pair even when it is ignored
    run_ignored();
    run_freeze();
    run_ea(csw_pkg::CSW_AM_REL, 16'h0080, 16'h0F80, 16'h4321);
    run_ea(csw_pkg::CSW_AM_REL, 16'h007F, 16'h107F, 16'h4321);
    run_ea(csw_pkg::CSW_AM_DIR, 16'h12AB, 16'h00AB, 16'h4321);
    run_ea(csw_pkg::CSW_AM_SP1, 16'h0080, 16'h007F, 16'h4321);
    run_ea(csw_pkg::CSW_AM_SP2, 16'h1001, 16'h1000, 16'h4321);
    run_ea(csw_pkg::CSW_AM_IX_PI, 16'h0055, 16'h4321, 16'h4322);
    run_ea(csw_pkg::CSW_AM_IX1_PI, 16'h00FF, 16'h4421, 16'h4323);
    run_wait();
    run_wait_reset();
    tally_and_finish();
  end
endmodule : tb_top
